/* File: design/xpt_host.sv */
// host controller that sequences the crosspoint array pins
//
// Function
// RULE_01: row codes 0-5 and 8-13 each reach one of twelve rows.
// RULE_02: unassigned row codes change nothing; host refuses them without strobing.
// RULE_03: every 3-bit column code reaches one of eight columns.
// RULE_04: close: present selects, data high, then raise strobe.
// RULE_05: open: same sequence with data low.
// RULE_06: strobe low means the array ignores address and data.
// RULE_07: selects settle for a setup time before strobe rises.
// RULE_08: data and selects held steady across and after strobe fall.
// RULE_09: master reset high opens all switches.
// RULE_10: any switch mix may be closed; each holds until addressed or reset.
// RULE_11: master reset rests low, pulses high, then returns low.
// RULE_12: each switch latches data while strobed, holds from strobe fall.
// RULE_13: reset has priority over strobe; host never strobes during reset.
`timescale 1ns/10ps
module xpt_host
  import xpt_pkg::*;
#(
  parameter int SETUP_T = SETUP_CYC,
  parameter int STROBE_T = STROBE_CYC,
  parameter int HOLD_T = HOLD_CYC,
  parameter int RESET_T = RESET_CYC,
  parameter int SETTLE_T = SETTLE_CYC
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire req_t req,
  input wire logic clear_all,
  output logic req_ready,
  output logic req_done,
  output logic req_refused,
  output logic clear_done,
  output pins_t pins,
  output logic [NUM_ROWS*NUM_COLS-1:0] shadow
);
  // true when a phase length fits the shared timer
  function automatic bit len_fits(input int n);
    len_fits = (n >= 1) && (n <= (1 << CNT_W));
  endfunction

  // refuse phase lengths that the timer cannot count
  if (!len_fits(SETUP_T) || !len_fits(STROBE_T) || !len_fits(HOLD_T) ||
      !len_fits(RESET_T) || !len_fits(SETTLE_T)) begin : g_bad_timing
    $error("xpt_host: phase length does not fit the timer");
  end

  typedef struct packed {
    phase_t phase;
    pins_t pins;
    logic ready;
    logic done;
    logic refused;
    logic cleared;
    logic [NUM_ROWS*NUM_COLS-1:0] shadow;
  } state_t;

  state_t s;
  state_t next_s;
  logic t_load;
  logic [CNT_W-1:0] t_val;
  logic t_done;

  // true for a row code that reaches a row
  function automatic logic row_valid(input logic [ROW_W-1:0] r);
    row_valid = !(r == ROW_GAP_A || r == ROW_GAP_B || r == ROW_GAP_C || r == ROW_GAP_D);
  endfunction

  // map a valid row code to its row number 0..11
  function automatic logic [ROW_W-1:0] row_index(input logic [ROW_W-1:0] r);
    if (r >= ROW_HIGH_BASE) begin
      row_index = r - ROW_HIGH_BASE + ROW_HALF;
    end else begin
      row_index = r;
    end
  endfunction

  // one timer serves every timed phase in turn
  xpt_timer u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .load(t_load),
    .load_val(t_val),
    .done(t_done)
  );

  // one-hot decode of the selects now standing on the pins
  logic [NUM_ROWS-1:0] row_hit;
  logic [NUM_COLS-1:0] col_hit;
  logic [NUM_ROWS*NUM_COLS-1:0] cell_hit;

  // unassigned row codes hit no row, so they can never touch the shadow
  for (genvar gr = 0; gr < NUM_ROWS; gr++) begin : g_row
    assign row_hit[gr] = row_valid(s.pins.row_select) &&
      (row_index(s.pins.row_select) == ROW_W'(gr)); // see RULE_01 RULE_02
  end

  // every column code reaches a column
  for (genvar gc = 0; gc < NUM_COLS; gc++) begin : g_col
    assign col_hit[gc] = (s.pins.column_select == COL_W'(gc)); // see RULE_03
  end

  // a crosspoint is hit when both its row and its column are
  for (genvar gr = 0; gr < NUM_ROWS; gr++) begin : g_cell_row
    for (genvar gc = 0; gc < NUM_COLS; gc++) begin : g_cell_col
      assign cell_hit[gr*NUM_COLS+gc] = row_hit[gr] && col_hit[gc];
    end
  end

  // phase sequencer
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.refused = 1'b0;
    next_s.cleared = 1'b0;
    t_load = 1'b0;
    t_val = '0;
    unique case (s.phase)
      ST_IDLE: begin
        // a clear wins over a switch request
        if (clear_all) begin
          next_s.pins.master_reset = 1'b1; // see RULE_11
          next_s.pins.strobe = 1'b0; // see RULE_13
          next_s.ready = 1'b0;
          next_s.phase = ST_RESET;
          t_load = 1'b1;
          t_val = CNT_W'(RESET_T - 1);
        end else if (req_valid) begin
          // an unassigned row is answered at once and never reaches the pins
          if (!row_valid(req.row)) begin
            next_s.refused = 1'b1; // see RULE_02
          end else begin
            // selects and data go out first and stand for the setup time
            next_s.pins.row_select = req.row; // see RULE_01
            next_s.pins.column_select = req.col; // see RULE_03
            next_s.pins.data = req.close; // see RULE_04
            next_s.ready = 1'b0;
            next_s.phase = ST_SETUP;
            t_load = 1'b1;
            t_val = CNT_W'(SETUP_T - 1); // see RULE_07
          end
        end
      end
      ST_SETUP: begin
        // setup time has run, raise strobe
        if (t_done) begin
          next_s.pins.strobe = 1'b1; // see RULE_04
          next_s.phase = ST_STROBE;
          t_load = 1'b1;
          t_val = CNT_W'(STROBE_T - 1);
        end
      end
      ST_STROBE: begin
        // pulse width has run, drop strobe but keep data and selects
        if (t_done) begin
          next_s.pins.strobe = 1'b0; // see RULE_12
          next_s.phase = ST_HOLD;
          t_load = 1'b1;
          t_val = CNT_W'(HOLD_T - 1); // see RULE_08
        end
      end
      ST_HOLD: begin
        // hold time has run, record the new state in the shadow copy
        if (t_done) begin
          for (int k = 0; k < NUM_ROWS*NUM_COLS; k++) begin
            if (cell_hit[k]) begin
              next_s.shadow[k] = s.pins.data; // see RULE_10
            end
          end
          next_s.done = 1'b1; // see RULE_05
          next_s.ready = 1'b1;
          next_s.phase = ST_IDLE; // see RULE_06
        end
      end
      ST_RESET: begin
        // reset pulse is long enough, the array is now all open
        if (t_done) begin
          next_s.pins.master_reset = 1'b0; // see RULE_11
          next_s.shadow = '0; // see RULE_09
          next_s.phase = ST_SETTLE;
          t_load = 1'b1;
          t_val = CNT_W'(SETTLE_T - 1);
        end
      end
      ST_SETTLE: begin
        // give the array outputs time to settle before the next request
        if (t_done) begin
          next_s.cleared = 1'b1;
          next_s.ready = 1'b1;
          next_s.phase = ST_IDLE;
        end
      end
      default: begin
        next_s.phase = ST_IDLE;
      end
    endcase
  end

  // state register, frozen while clk_en is low
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      // idle and ready, every pin at rest
      s <= '0;
      s.ready <= 1'b1;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // outputs come straight from the state register
  assign pins = s.pins;
  assign req_ready = s.ready;
  assign req_done = s.done;
  assign req_refused = s.refused;
  assign clear_done = s.cleared;
  assign shadow = s.shadow;
endmodule

/* File: design/xpt_pkg.sv */
// constants and types shared by the crosspoint host controller
package xpt_pkg;
  localparam int NUM_ROWS = 12;
  localparam int NUM_COLS = 8;
  localparam int ROW_W = 4;
  localparam int COL_W = 3;
  // timing figures in ns and derived cycle counts at the system clock rate
  localparam int CLK_PERIOD_NS = 40;
  localparam int SETUP_NS = 20;
  localparam int HOLD_NS = 20;
  localparam int STROBE_PW_NS = 30;
  localparam int RESET_PW_NS = 50;
  localparam int SETTLE_NS = 200;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC = (RESET_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // row codes 6, 7, 14 and 15 reach no row
  localparam logic [ROW_W-1:0] ROW_GAP_A = 4'h6;
  localparam logic [ROW_W-1:0] ROW_GAP_B = 4'h7;
  localparam logic [ROW_W-1:0] ROW_GAP_C = 4'he;
  localparam logic [ROW_W-1:0] ROW_GAP_D = 4'hf;
  localparam logic [ROW_W-1:0] ROW_HALF = 4'h6;
  localparam logic [ROW_W-1:0] ROW_HIGH_BASE = 4'h8;

  // pins toward the switch array
  typedef struct packed {
    logic [ROW_W-1:0] row_select;
    logic [COL_W-1:0] column_select;
    logic data;
    logic strobe;
    logic master_reset;
  } pins_t;

  // user request
  typedef struct packed {
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic close;
  } req_t;

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RESET, ST_SETTLE} phase_t;
endpackage

/* File: design/xpt_timer.sv */
// down counter that marks the end of a timed phase
`timescale 1ns/10ps
module xpt_timer
  import xpt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  output logic done
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } tstate_t;
  tstate_t s;
  tstate_t next_s;

  // load wins, otherwise count down to zero
  always_comb begin
    next_s = s;
    if (load) begin
      next_s.cnt = load_val;
    end else if (s.cnt != '0) begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // zero count ends the phase; done must not look at load, which the caller derives from done
  assign done = (s.cnt == '0);
endmodule

/* File: tb/tb.sv */
// self-checking host controller bench
`timescale 1ns/10ps
module tb
  import xpt_pkg::*;
;
  logic clk_sys = 0, resetn = 0, clk_en = 1, req_valid = 0, clear_all = 0;
  logic req_ready, req_done, req_refused, clear_done;
  req_t req = '0;
  pins_t pins;
  logic [95:0] shadow, sw, exp_sw = '0;
  int mismatches = 0, n_tests = 0, cyc = 0;
  always #20 clk_sys = ~clk_sys;
  xpt_host dut_u (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .req_valid(req_valid),
    .req(req),
    .clear_all(clear_all),
    .req_ready(req_ready),
    .req_done(req_done),
    .req_refused(req_refused),
    .clear_done(clear_done),
    .pins(pins),
    .shadow(shadow)
  );
  xpt_array_model arr_u (.pins(pins), .sw(sw));
  task chk(input logic [191:0] got, want);
    n_tests++;
    if (got !== want) mismatches++;
    if (got !== want) $display("wrong value %0t %h %h", $time, got, want);
  endtask
  task end_of_test;
    $display("%0d compares %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // cut a hung run short
  always @(posedge clk_sys) if (++cyc == 3000) begin
    mismatches++;
    end_of_test;
  end
  task automatic op(logic [3:0] r, logic [2:0] c, logic cl);
    req_valid <= 1;
    req <= '{r, c, cl};
    do @(posedge clk_sys); while (!req_ready);
    req_valid <= 0;
    do @(posedge clk_sys); while (!(req_done || req_refused));
    chk(req_refused, r[2:1] == 2'b11);
    if (r[2:1] != 2'b11) exp_sw[(r[3] ? r - 4'h2 : r) * 8 + c] = cl;
  endtask
  task cmp(input string s);
    chk({shadow, sw}, {exp_sw, exp_sw});
    $display("end of test %s", s);
  endtask
  task clr;
    clear_all <= 1;
    do @(posedge clk_sys); while (!req_ready);
    clear_all <= 0;
    do @(posedge clk_sys); while (!clear_done);
    exp_sw = '0;
    cmp("clear");
  endtask
  task t_rows;
    for (int r = 0; r < 16; r++) op(4'(r), 3'(r + r / 8 * 2), 1);
    op(4'h3, 3'h3, 0);
    op(4'hd, 3'h7, 0);
    cmp("rows");
  endtask
  // freeze the controller between take and strobe, then let it finish
  task t_freeze;
    req_valid <= 1;
    req <= '{4'h0, 3'h7, 1'b1};
    do @(posedge clk_sys); while (!req_ready);
    req_valid <= 0;
    clk_en <= 0;
    repeat (4) @(posedge clk_sys);
    chk({req_ready, req_done, pins}, {2'b00, 4'h0, 3'h7, 3'b100});
    clk_en <= 1;
    do @(posedge clk_sys); while (!req_done);
    exp_sw[7] = 1;
    cmp("freeze");
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1;
    clr;
    t_rows;
    t_freeze;
    clr;
    end_of_test;
  end
endmodule

/* File: tb/xpt_array_model.sv */
// behavioural switch array seen by the host
`timescale 1ns/10ps
module xpt_array_model
  import xpt_pkg::*;
(
  input wire pins_t pins,
  output logic [95:0] sw
);
  wire logic [3:0] r = pins.row_select;
  // switches follow data while strobed, reset wins
  always_latch begin
    if (pins.master_reset) sw = '0;
    else if (pins.strobe && r[2:1] != 2'b11)
      sw[(r[3] ? r - 4'h2 : r) * 8 + pins.column_select] = pins.data;
  end
endmodule

/* File: tb/xpt_host_asserts.sv */
// timing checks on the host controller ports
`timescale 1ns/10ps
module xpt_host_asserts
  import xpt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire req_t req,
  input wire logic clear_all,
  input wire logic req_ready,
  input wire logic req_done,
  input wire logic req_refused,
  input wire logic clear_done,
  input wire pins_t pins,
  input wire logic [NUM_ROWS*NUM_COLS-1:0] shadow
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_SETUP: assert property ($rose(pins.strobe) |-> $stable(pins[9:2]))
    else $error("setup");
  AST_HOLD: assert property ($fell(pins.strobe) |-> $stable(pins[9:2]))
    else $error("hold");
  AST_PRIO: assert property (pins.master_reset |-> !pins.strobe)
    else $error("prio");
  AST_OP: assert property ((req_valid && req_ready && clk_en && !clear_all
    && req.row[2:1] != 2'b11) ##1 clk_en [*3] |-> !req_ready && !$past(req_ready)
    && !$past(req_ready, 2) ##1 req_done) else $error("timing");
  AST_RST_W: assert property ($rose(pins.master_reset) && clk_en ##1 clk_en |->
    pins.master_reset ##1 !pins.master_reset) else $error("width");
  AST_REFUSE: assert property (req_valid && req_ready && clk_en && !clear_all
    && req.row[2:1] == 2'b11 |=> req_refused && req_ready && !pins.strobe) else $error("refuse");
  AST_CLEAR: assert property ($fell(pins.master_reset) |-> shadow == '0)
    else $error("clear");
  cover property (req_done);
  cover property (req_refused);
  cover property (clear_done);
  cover property (!clk_en && !req_ready);
endmodule
bind xpt_host xpt_host_asserts chk_u (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .clk_en(clk_en),
  .req_valid(req_valid),
  .req(req),
  .clear_all(clear_all),
  .req_ready(req_ready),
  .req_done(req_done),
  .req_refused(req_refused),
  .clear_done(clear_done),
  .pins(pins),
  .shadow(shadow)
);
